//--- rtl/vcc_comparator_control.sv
`timescale 1ns/1ps
module vcc_comparator_control
   import vcc_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic CMP_RAW,
   input wire logic GLOBAL_IRQ_ENABLE,
   output logic COMPARATOR_ON,
   output logic [1:0] POWER_SPEED_SELECT,
   output logic [15:0] PLUS_CHAN_SEL,
   output logic [15:0] MINUS_CHAN_SEL,
   output logic INPUT_SWAP,
   output logic INPUT_SHORT,
   output logic [4:0] REF_LEVEL,
   output logic REF_ON_MINUS,
   output logic [15:0] PIN_BUF_DISABLE,
   output logic COMPARISON_RESULT,
   output logic IRQ
);

   // byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (strb[0]) begin
         v[7:0] = data[7:0];
      end
      if (strb[1]) begin
         v[15:8] = data[15:8];
      end
      return v & mask;
   endfunction : merge16

   // one-hot channel decode, empty when disabled
   function automatic logic [15:0] chan_decode(input logic en, input logic [3:0] sel);
      logic [15:0] v;
      v = 16'h0000;
      if (en) begin
         v[sel] = 1'b1;
      end
      return v;
   endfunction : chan_decode

   // filter delay in cycles per setting
   function automatic logic [4:0] filt_cycles(input logic [1:0] sel);
      logic [4:0] v;
      unique case (sel)
         2'h0: v = FILT0_CYC;
         2'h1: v = FILT1_CYC;
         2'h2: v = FILT2_CYC;
         2'h3: v = FILT3_CYC;
      endcase
      return v;
   endfunction : filt_cycles

   // software registers
   logic [15:0] input_select_control_reg;
   logic [15:0] operation_control_reg;
   logic [15:0] reference_control_reg;
   logic [15:0] port_buffer_disable_reg;
   logic [15:0] interrupt_flag_enable_reg;
   logic [15:0] interrupt_flag_enable_next;
   // write channel state
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic do_write;
   // read channel state
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic vec_read;
   // comparator datapath
   logic cand;
   logic filt_reg;
   logic [4:0] filt_cnt_reg;
   logic result_reg;
   logic prev_result_reg;
   logic set_main;
   logic set_inv;
   logic [15:0] vec_word;
   // registered outputs
   logic [15:0] plus_sel_reg;
   logic [15:0] minus_sel_reg;
   logic [15:0] pin_dis_reg;
   logic [4:0] ref_level_reg;
   logic irq_reg;

   // short names for control bits
   logic cmp_on;
   logic swap_en;
   logic filter_en;
   logic edge_sel;
   assign cmp_on = operation_control_reg[ON_BIT];
   assign swap_en = operation_control_reg[SWAP_BIT];
   assign filter_en = operation_control_reg[FILTER_EN_BIT];
   assign edge_sel = operation_control_reg[EDGE_SEL_BIT];

   // write happens once address and data are both held
   assign do_write = !awready_reg && !wready_reg && !bvalid_reg;

   // write address, data and response channels
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
      end else begin
         // address taken
         if (awready_reg && S_AXI_AWVALID) begin
            awaddr_reg <= S_AXI_AWADDR;
            awready_reg <= 1'b0;
         end
         // data taken
         if (wready_reg && S_AXI_WVALID) begin
            wdata_reg <= S_AXI_WDATA;
            wstrb_reg <= S_AXI_WSTRB;
            wready_reg <= 1'b0;
         end
         // response after both halves
         if (do_write) begin
            bvalid_reg <= 1'b1;
            unique case (awaddr_reg)
               ADDR_INPUT_SEL, ADDR_OPERATION, ADDR_REFERENCE, ADDR_PORT_DIS, ADDR_INT_FLAG,
               ADDR_INT_VEC: bresp_reg <= RESP_OKAY;
               default: bresp_reg <= RESP_SLVERR;
            endcase
         end
         // response accepted, reopen
         if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   // control registers, written by software
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         input_select_control_reg <= REG_RESET;
         operation_control_reg <= REG_RESET;
         reference_control_reg <= REG_RESET;
         port_buffer_disable_reg <= REG_RESET;
      end else if (do_write) begin
         unique case (awaddr_reg)
            ADDR_INPUT_SEL: input_select_control_reg <= merge16(input_select_control_reg,
               wdata_reg, wstrb_reg, MASK_INPUT_SEL);
            ADDR_OPERATION: operation_control_reg <= merge16(operation_control_reg,
               wdata_reg, wstrb_reg, MASK_OPERATION);
            ADDR_REFERENCE: reference_control_reg <= merge16(reference_control_reg,
               wdata_reg, wstrb_reg, MASK_REFERENCE);
            ADDR_PORT_DIS: port_buffer_disable_reg <= merge16(port_buffer_disable_reg,
               wdata_reg, wstrb_reg, MASK_PORT_DIS);
            default: ;
         endcase
      end
   end

   // vector: main flag first, then inverted flag
   always_comb begin
      if (interrupt_flag_enable_reg[FLAG_BIT] && interrupt_flag_enable_reg[IE_BIT]) begin
         vec_word = VEC_FLAG;
      end else if (interrupt_flag_enable_reg[IFLAG_BIT] && interrupt_flag_enable_reg[IIE_BIT]) begin
         vec_word = VEC_IFLAG;
      end else begin
         vec_word = VEC_NONE;
      end
   end

   // a vector read takes the reported flag
   assign vec_read = arready_reg && S_AXI_ARVALID && (S_AXI_ARADDR == ADDR_INT_VEC);

   // read address and data channels
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
      end else begin
         if (arready_reg && S_AXI_ARVALID) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rresp_reg <= RESP_OKAY;
            unique case (S_AXI_ARADDR)
               ADDR_INPUT_SEL: rdata_reg <= {16'h0000, input_select_control_reg};
               ADDR_OPERATION: rdata_reg <= {16'h0000, operation_control_reg[15:1], result_reg};
               ADDR_REFERENCE: rdata_reg <= {16'h0000, reference_control_reg};
               ADDR_PORT_DIS: rdata_reg <= {16'h0000, port_buffer_disable_reg};
               ADDR_INT_FLAG: rdata_reg <= {16'h0000, interrupt_flag_enable_reg};
               ADDR_INT_VEC: rdata_reg <= {16'h0000, vec_word};
               default: begin
                  // unmapped: zero with slave error
                  rdata_reg <= 32'h0000_0000;
                  rresp_reg <= RESP_SLVERR;
               end
            endcase
         end
         // data accepted, reopen
         if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // candidate result: gated by on, inverted by swap
   assign cand = cmp_on && (CMP_RAW ^ swap_en);

   // digital output filter: change must persist the set delay
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         filt_reg <= 1'b0;
         filt_cnt_reg <= 5'h00;
      end else if (!cmp_on) begin
         filt_reg <= 1'b0;
         filt_cnt_reg <= 5'h00;
      end else if (cand == filt_reg) begin
         filt_cnt_reg <= 5'h00;
      end else if (filt_cnt_reg + 5'h01 >= filt_cycles(operation_control_reg[FILT_DLY_LSB +: 2])) begin
         filt_reg <= cand;
         filt_cnt_reg <= 5'h00;
      end else begin
         filt_cnt_reg <= filt_cnt_reg + 5'h01;
      end
   end

   // result and edge history
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         result_reg <= 1'b0;
         prev_result_reg <= 1'b0;
      end else begin
         prev_result_reg <= result_reg;
         if (!cmp_on) begin
            result_reg <= 1'b0;
         end else if (filter_en) begin
            result_reg <= filt_reg;
         end else begin
            result_reg <= cand;
         end
      end
   end

   // edge select picks polarity for both flags
   assign set_main = edge_sel ? (prev_result_reg && !result_reg)
                              : (!prev_result_reg && result_reg);
   assign set_inv = edge_sel ? (!prev_result_reg && result_reg)
                             : (prev_result_reg && !result_reg);

   // interrupt register next value; hardware set wins
   always_comb begin
      interrupt_flag_enable_next = interrupt_flag_enable_reg;
      if (do_write && awaddr_reg == ADDR_INT_FLAG) begin
         // writing zero clears a flag
         interrupt_flag_enable_next = merge16(interrupt_flag_enable_reg, wdata_reg, wstrb_reg,
            MASK_INT_FLAG);
      end
      if (vec_read && vec_word == VEC_FLAG) begin
         interrupt_flag_enable_next[FLAG_BIT] = 1'b0;
      end else if (vec_read && vec_word == VEC_IFLAG) begin
         interrupt_flag_enable_next[IFLAG_BIT] = 1'b0;
      end
      if (set_main) begin
         interrupt_flag_enable_next[FLAG_BIT] = 1'b1;
      end
      if (set_inv) begin
         interrupt_flag_enable_next[IFLAG_BIT] = 1'b1;
      end
   end

   // interrupt register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         interrupt_flag_enable_reg <= REG_RESET;
      end else begin
         interrupt_flag_enable_reg <= interrupt_flag_enable_next;
      end
   end

   // interrupt request, gated by enables and global enable
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= GLOBAL_IRQ_ENABLE && (vec_word != VEC_NONE);
      end
   end

   // channel selects and pin buffer disables
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         plus_sel_reg <= 16'h0000;
         minus_sel_reg <= 16'h0000;
         pin_dis_reg <= 16'h0000;
      end else begin
         plus_sel_reg <= chan_decode(input_select_control_reg[PLUS_EN_BIT],
            input_select_control_reg[PLUS_SEL_LSB +: 4]);
         minus_sel_reg <= chan_decode(input_select_control_reg[MINUS_EN_BIT],
            input_select_control_reg[MINUS_SEL_LSB +: 4]);
         pin_dis_reg <= port_buffer_disable_reg
            | chan_decode(input_select_control_reg[PLUS_EN_BIT],
                          input_select_control_reg[PLUS_SEL_LSB +: 4])
            | chan_decode(input_select_control_reg[MINUS_EN_BIT],
                          input_select_control_reg[MINUS_SEL_LSB +: 4]);
      end
   end

   // reference level: result or manual bit picks the tap
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ref_level_reg <= 5'h00;
      end else if (operation_control_reg[MAN_SEL_BIT]) begin
         ref_level_reg <= operation_control_reg[MAN_LEVEL_BIT]
            ? reference_control_reg[REF_HIGH_LSB +: 5]
            : reference_control_reg[REF_LOW_LSB +: 5];
      end else begin
         ref_level_reg <= result_reg ? reference_control_reg[REF_HIGH_LSB +: 5]
                                     : reference_control_reg[REF_LOW_LSB +: 5];
      end
   end

   // port drive: all from flip-flops
   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign COMPARATOR_ON = cmp_on;
   assign POWER_SPEED_SELECT = reference_control_reg[PWR_LSB +: 2];
   assign PLUS_CHAN_SEL = plus_sel_reg;
   assign MINUS_CHAN_SEL = minus_sel_reg;
   assign INPUT_SWAP = swap_en;
   assign INPUT_SHORT = operation_control_reg[SHORT_BIT];
   assign REF_LEVEL = ref_level_reg;
   assign REF_ON_MINUS = reference_control_reg[REF_TERM_BIT];
   assign PIN_BUF_DISABLE = pin_dis_reg;
   assign COMPARISON_RESULT = result_reg;
   assign IRQ = irq_reg;

   // checks
   a_off_result_low: assert property (@(posedge CLK) disable iff (!RST_N)
      !cmp_on |=> !result_reg) else $error("result not low while off");
   a_unfilt_swap_result: assert property (@(posedge CLK) disable iff (!RST_N)
      (cmp_on && !filter_en) |=> result_reg == $past(CMP_RAW ^ swap_en))
      else $error("unfiltered result wrong");
   a_filter_hold_time: assert property (@(posedge CLK) disable iff (!RST_N)
      ($past(cmp_on) && cmp_on && filt_reg != $past(filt_reg)) |->
      $past(filt_cnt_reg) + 5'h01 >= $past(filt_cycles(operation_control_reg[7:6])))
      else $error("filter switched early");
   a_plus_onehot_sel: assert property (@(posedge CLK) disable iff (!RST_N)
      $onehot0(plus_sel_reg) && $onehot0(minus_sel_reg)) else $error("two pins on terminal");
   a_pin_buf_sel: assert property (@(posedge CLK) disable iff (!RST_N)
      input_select_control_reg[PLUS_EN_BIT] |=>
      pin_dis_reg[$past(input_select_control_reg[3:0])]) else $error("selected pin buffer on");
   a_hyst_ref_high: assert property (@(posedge CLK) disable iff (!RST_N)
      (!operation_control_reg[MAN_SEL_BIT] && result_reg) |=>
      ref_level_reg == $past(reference_control_reg[12:8])) else $error("high ref not used");
   a_rise_sets_flag: assert property (@(posedge CLK) disable iff (!RST_N)
      (!edge_sel && $rose(result_reg)) |=> interrupt_flag_enable_reg[FLAG_BIT])
      else $error("rising edge missed");
   a_fall_sets_iflag: assert property (@(posedge CLK) disable iff (!RST_N)
      (!edge_sel && $fell(result_reg)) |=> interrupt_flag_enable_reg[IFLAG_BIT])
      else $error("falling edge missed");
   a_irq_needs_global: assert property (@(posedge CLK) disable iff (!RST_N)
      irq_reg |-> $past(GLOBAL_IRQ_ENABLE) && $past(vec_word) != VEC_NONE)
      else $error("irq without enables");
   a_vec_idle_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      !(interrupt_flag_enable_reg[FLAG_BIT] && interrupt_flag_enable_reg[IE_BIT]) &&
      !(interrupt_flag_enable_reg[IFLAG_BIT] && interrupt_flag_enable_reg[IIE_BIT]) |->
      vec_word == VEC_NONE) else $error("vector not zero");
   a_write_resp_time: assert property (@(posedge CLK) disable iff (!RST_N)
      (awready_reg && S_AXI_AWVALID && wready_reg && S_AXI_WVALID) |=> ##1 bvalid_reg)
      else $error("write response late");

endmodule : vcc_comparator_control

//--- rtl/vcc_pkg.sv
// Overview of operation
// - result high when plus above minus
// - on bit gates result; off reads low
// - power field resets 0, 2 slowest
// - separate plus and minus channel fields
// - one pin per terminal at most
// - swap exchanges inputs, inverts result
// - short bit ties terminals together
// - filter enable with four delay steps
// - result one picks high reference level
// - reference goes to selected terminal
// - disable bits kill pin input buffers
// - selected input pin buffer always disabled
// - flag set on chosen result edge
// - irq needs flag, enable, global enable
// - registers at documented offsets
// - all registers reset to zero
// - edge select sets both flag polarities
// - manual select overrides result for reference
package vcc_pkg;
   // clock period in ns
   localparam int unsigned CLK_PERIOD_NS = 100;
   // register indices and byte addresses
   localparam logic [7:0] IDX_INPUT_SEL = 8'h00;
   localparam logic [7:0] IDX_OPERATION = 8'h02;
   localparam logic [7:0] IDX_REFERENCE = 8'h04;
   localparam logic [7:0] IDX_PORT_DIS = 8'h06;
   localparam logic [7:0] IDX_INT_FLAG = 8'h0c;
   localparam logic [7:0] IDX_INT_VEC = 8'h0e;
   localparam logic [7:0] ADDR_INPUT_SEL = 8'(IDX_INPUT_SEL * 4);
   localparam logic [7:0] ADDR_OPERATION = 8'(IDX_OPERATION * 4);
   localparam logic [7:0] ADDR_REFERENCE = 8'(IDX_REFERENCE * 4);
   localparam logic [7:0] ADDR_PORT_DIS = 8'(IDX_PORT_DIS * 4);
   localparam logic [7:0] ADDR_INT_FLAG = 8'(IDX_INT_FLAG * 4);
   localparam logic [7:0] ADDR_INT_VEC = 8'(IDX_INT_VEC * 4);
   // reset value of every register
   localparam logic [15:0] REG_RESET = 16'h0000;
   // writable bit masks
   localparam logic [15:0] MASK_INPUT_SEL = 16'h8f8f;
   localparam logic [15:0] MASK_OPERATION = 16'h1cfc;
   localparam logic [15:0] MASK_REFERENCE = 16'hff1f;
   localparam logic [15:0] MASK_PORT_DIS = 16'hffff;
   localparam logic [15:0] MASK_INT_FLAG = 16'h0303;
   // input select fields
   localparam int unsigned PLUS_SEL_LSB = 0;
   localparam int unsigned PLUS_EN_BIT = 7;
   localparam int unsigned MINUS_SEL_LSB = 8;
   localparam int unsigned MINUS_EN_BIT = 15;
   // operation control fields
   localparam int unsigned RESULT_BIT = 0;
   localparam int unsigned FILTER_EN_BIT = 2;
   localparam int unsigned EDGE_SEL_BIT = 3;
   localparam int unsigned SHORT_BIT = 4;
   localparam int unsigned SWAP_BIT = 5;
   localparam int unsigned FILT_DLY_LSB = 6;
   localparam int unsigned ON_BIT = 10;
   localparam int unsigned MAN_LEVEL_BIT = 11;
   localparam int unsigned MAN_SEL_BIT = 12;
   // reference control fields
   localparam int unsigned REF_LOW_LSB = 0;
   localparam int unsigned REF_HIGH_LSB = 8;
   localparam int unsigned PWR_LSB = 13;
   localparam int unsigned REF_TERM_BIT = 15;
   // power and speed codes
   localparam logic [1:0] PWR_FASTEST = 2'h0;
   localparam logic [1:0] PWR_SLOWEST = 2'h2;
   // interrupt register fields
   localparam int unsigned FLAG_BIT = 0;
   localparam int unsigned IFLAG_BIT = 1;
   localparam int unsigned IE_BIT = 8;
   localparam int unsigned IIE_BIT = 9;
   // vector codes
   localparam logic [15:0] VEC_NONE = 16'h0000;
   localparam logic [15:0] VEC_FLAG = 16'h0002;
   localparam logic [15:0] VEC_IFLAG = 16'h0004;
   // filter delays in ns and in cycles
   localparam int unsigned FILT0_NS = 500;
   localparam int unsigned FILT1_NS = 900;
   localparam int unsigned FILT2_NS = 1600;
   localparam int unsigned FILT3_NS = 3000;
   localparam logic [4:0] FILT0_CYC = 5'(FILT0_NS / CLK_PERIOD_NS);
   localparam logic [4:0] FILT1_CYC = 5'(FILT1_NS / CLK_PERIOD_NS);
   localparam logic [4:0] FILT2_CYC = 5'(FILT2_NS / CLK_PERIOD_NS);
   localparam logic [4:0] FILT3_CYC = 5'(FILT3_NS / CLK_PERIOD_NS);
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : vcc_pkg

//--- verification/vcc_analog_model.sv
`timescale 1ns/1ps
// far-side model: pin voltages routed through the analog switches
module vcc_analog_model
   import vcc_pkg::*;
(
   input wire logic [15:0] PLUS_CHAN_SEL,
   input wire logic [15:0] MINUS_CHAN_SEL,
   input wire logic INPUT_SWAP,
   input wire logic INPUT_SHORT,
   output logic CMP_RAW
);
   int pin_mv [16]; // pin voltages in mV, set by the bench
   int vp; // plus terminal level
   int vm; // minus terminal level
   int t; // swap scratch
   // terminal levels and raw comparison
   always_comb begin
      vp = 0;
      vm = 0;
      for (int i = 0; i < 16; i++) begin
         if (PLUS_CHAN_SEL[i]) vp = pin_mv[i];
         if (MINUS_CHAN_SEL[i]) vm = pin_mv[i];
      end
      t = vp;
      if (INPUT_SWAP) begin
         vp = vm;
         vm = t;
      end
      if (INPUT_SHORT) vm = vp;
      CMP_RAW = (vp > vm);
   end
endmodule : vcc_analog_model

//--- verification/tb.sv
`timescale 1ns/1ps
module tb
   import vcc_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, glob_irq_en = 1'b0; // clock, reset, global enable
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00; // bus addresses
   logic [31:0] wdata = 32'h0; // write data
   logic awready, wready, bvalid, arready, rvalid, cmp_raw, on, swp, shrt, refm, res, irq;
   logic [1:0] bresp, rresp, pwr;
   logic [31:0] rdata;
   logic [15:0] psel, msel, pbd;
   logic [4:0] rlvl;
   int errors = 0, cmp_count = 0; // tallies
   logic [31:0] d; // read value
   logic [1:0] r; // response code
   vcc_comparator_control DUT (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'h3), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CMP_RAW(cmp_raw),
      .GLOBAL_IRQ_ENABLE(glob_irq_en), .COMPARATOR_ON(on), .POWER_SPEED_SELECT(pwr),
      .PLUS_CHAN_SEL(psel), .MINUS_CHAN_SEL(msel), .INPUT_SWAP(swp), .INPUT_SHORT(shrt),
      .REF_LEVEL(rlvl), .REF_ON_MINUS(refm), .PIN_BUF_DISABLE(pbd),
      .COMPARISON_RESULT(res), .IRQ(irq));
   vcc_analog_model ana (.PLUS_CHAN_SEL(psel), .MINUS_CHAN_SEL(msel), .INPUT_SWAP(swp),
      .INPUT_SHORT(shrt), .CMP_RAW(cmp_raw));
   // clock and watchdog
   initial begin
      forever #50 clk = ~clk;
   end
   initial begin
      #3000000;
      errors++;
      wrap_up();
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // one write; sample at negedge, act at the following rising edge
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      logic ta, tw, tb_;
      int n;
      @(posedge clk);
      awaddr <= a; awvalid <= 1'b1; wdata <= {16'h0, v}; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge clk);
         ta = awvalid & awready; tw = wvalid & wready; tb_ = bvalid; r = bresp;
         @(posedge clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (tb_) break;
      end
      bready <= 1'b0;
      if (n == 60) chk(1'b0, 1'b1, "write hang");
   endtask : wr
   // one read
   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      int n;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 60; n++) begin
         @(negedge clk);
         ta = arvalid & arready; tr = rvalid; d = rdata; r = rresp;
         @(posedge clk);
         if (ta) arvalid <= 1'b0;
         if (tr) break;
      end
      rready <= 1'b0;
      if (n == 60) chk(1'b0, 1'b1, "read hang");
   endtask : rd
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   // reset values, masks, unmapped place
   task automatic t_regs();
      logic [7:0] ad [5] = '{ADDR_INPUT_SEL, ADDR_REFERENCE, ADDR_PORT_DIS, ADDR_INT_FLAG,
         ADDR_OPERATION};
      logic [15:0] mk [5] = '{MASK_INPUT_SEL, MASK_REFERENCE, MASK_PORT_DIS, MASK_INT_FLAG,
         16'h0000};
      rd(ADDR_INT_VEC); chk(d, 32'h0, "vector reset");
      chk(pwr, PWR_FASTEST, "power reset");
      for (int i = 0; i < 5; i++) begin
         rd(ad[i]); chk(d, 32'h0, "reset value");
         if (i < 4) begin
            wr(ad[i], 16'hffff); chk(r, RESP_OKAY, "write okay");
            rd(ad[i]); chk(d, {16'h0, mk[i]}, "mask");
            wr(ad[i], 16'h0000);
         end
      end
      chk(irq, 1'b0, "irq without global enable");
      rd(8'h04); chk(r, RESP_SLVERR, "unmapped read");
      wr(8'h44, 16'h1234); chk(r, RESP_SLVERR, "unmapped write");
      $display("test regs done");
   endtask : t_regs
   // routing, on/off, swap, short
   task automatic t_cmp();
      ana.pin_mv[1] <= 800; ana.pin_mv[2] <= 300;
      wr(ADDR_INPUT_SEL, 16'h8281); wr(ADDR_PORT_DIS, 16'h0100); cyc(2);
      chk(psel, 16'h0002, "plus route"); chk(msel, 16'h0004, "minus route");
      chk(pbd, 16'h0106, "buffer disable");
      wr(ADDR_OPERATION, 16'h0400); cyc(3); chk(res, 1'b1, "plus above");
      chk(on, 1'b1, "on output");
      rd(ADDR_OPERATION); chk(d, 32'h0401, "result bit");
      wr(ADDR_OPERATION, 16'h0420); cyc(3); chk(res, 1'b1, "swap");
      chk(swp, 1'b1, "swap output");
      wr(ADDR_OPERATION, 16'h0410); cyc(3); chk(res, 1'b0, "short");
      chk(shrt, 1'b1, "short output");
      wr(ADDR_OPERATION, 16'h0000); cyc(3); chk(res, 1'b0, "off");
      chk(on, 1'b0, "off output");
      $display("test compare done");
   endtask : t_cmp
   // hysteresis reference, manual level, power
   task automatic t_ref();
      wr(ADDR_REFERENCE, 16'h9a05); cyc(3);
      chk(rlvl, 5'h05, "low tap"); chk(refm, 1'b1, "ref terminal");
      wr(ADDR_OPERATION, 16'h0400); cyc(3); chk(rlvl, 5'h1a, "high tap");
      wr(ADDR_OPERATION, 16'h1400); cyc(3); chk(rlvl, 5'h05, "manual low");
      wr(ADDR_OPERATION, 16'h1c00); cyc(3); chk(rlvl, 5'h1a, "manual high");
      wr(ADDR_REFERENCE, 16'h4000); cyc(2); chk(pwr, PWR_SLOWEST, "power");
      $display("test reference done");
   endtask : t_ref
   // edge flags, vector, enables
   task automatic t_irq();
      ana.pin_mv[1] <= 100;
      wr(ADDR_OPERATION, 16'h0400); wr(ADDR_INT_FLAG, 16'h0100); glob_irq_en <= 1'b1;
      ana.pin_mv[1] <= 800; cyc(4); chk(irq, 1'b1, "rising irq");
      rd(ADDR_INT_VEC); chk(d, {16'h0, VEC_FLAG}, "vector");
      rd(ADDR_INT_FLAG); chk(d, 32'h0100, "vector read clears");
      ana.pin_mv[1] <= 100; cyc(4); chk(irq, 1'b0, "inverted not enabled");
      rd(ADDR_INT_FLAG); chk(d, 32'h0102, "falling flag");
      wr(ADDR_OPERATION, 16'h0408); wr(ADDR_INT_FLAG, 16'h0300); glob_irq_en <= 1'b0;
      ana.pin_mv[1] <= 800; cyc(4); rd(ADDR_INT_FLAG); chk(d, 32'h0302, "reversed");
      chk(irq, 1'b0, "global off");
      glob_irq_en <= 1'b1; cyc(3); chk(irq, 1'b1, "global on");
      wr(ADDR_INT_FLAG, 16'h0000); cyc(3); chk(irq, 1'b0, "cleared");
      glob_irq_en <= 1'b0;
      $display("test irq done");
   endtask : t_irq
   // filter: five cycle hold, short pulse rejected, longest setting
   task automatic t_filt();
      ana.pin_mv[1] <= 100;
      wr(ADDR_OPERATION, 16'h0404); cyc(12);
      ana.pin_mv[1] <= 800; cyc(3); chk(res, 1'b0, "filter hold");
      cyc(9); chk(res, 1'b1, "filter pass");
      ana.pin_mv[1] <= 100; cyc(2); chk(res, 1'b1, "glitch held");
      ana.pin_mv[1] <= 800; cyc(12);
      chk(res, 1'b1, "glitch rejected");
      wr(ADDR_OPERATION, 16'h04c4); ana.pin_mv[1] <= 100;
      cyc(25); chk(res, 1'b1, "long hold");
      cyc(10); chk(res, 1'b0, "long pass");
      $display("test filter done");
   endtask : t_filt
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_regs(); t_cmp(); t_ref(); t_irq(); t_filt();
      wrap_up();
   end
endmodule : tb
